// [include/ocpm_pkg.sv]
// constants and types of the power-up mode select and fuse configuration loader
// assumes one 40 MHz core clock and a fuse array readable one cell per cycle
package ocpm_pkg;

  // ==========================================================================
  // configuration word layout
  localparam int WORD_W     = 70;
  localparam int USE_BIT    = 0;
  localparam int BANK_BIT   = 1;
  localparam int BANK1_OFS  = 33;
  localparam int LEV_LSB    = 2;
  localparam int LED_LSB    = 24;
  localparam int CAL_LSB    = 27;
  localparam int MON_LSB    = 29;
  localparam int CREEP_LSB  = 31;
  localparam int GAIN_LSB   = 33;
  localparam int LEV_W      = 22;
  localparam logic [6:0] LAST_CELL = 7'h45;

  // ==========================================================================
  // hard-coded defaults, used while the use-stored bit is clear
  localparam logic [1:0]  DEF_GAIN  = 2'h3;
  localparam logic [1:0]  DEF_CREEP = 2'h1;
  localparam logic [1:0]  DEF_MON   = 2'h2;
  localparam logic [1:0]  DEF_CAL   = 2'h1;
  localparam logic [2:0]  DEF_LED   = 3'h5;
  localparam logic [21:0] DEF_LEV   = 22'h06a6d4;

  // ==========================================================================
  // pulse dividers: internal pulse weight is 1/51200 kWh
  localparam logic [9:0] DIV_BASE  = 10'h200;
  localparam logic [3:0] FAST_SH   = 4'h3;
  localparam logic [2:0] LED_MAX   = 3'h6;

  // ==========================================================================
  // register map, byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CFG    = 8'h08;
  localparam logic [7:0] REG_LEV    = 8'h0c;
  localparam logic       CTRL_RST   = 1'h1;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;

  typedef enum logic [3:0] {
    ST_SAMPLE = 4'h1,
    ST_READ   = 4'h2,
    ST_RUN    = 4'h4,
    ST_BURN   = 4'h8
  } ocpm_state_t;

  typedef struct packed {
    logic [1:0]  gain;
    logic [1:0]  creep;
    logic [1:0]  mon;
    logic [1:0]  cal;
    logic [2:0]  led;
    logic [21:0] lev;
    logic        bank;
    logic        useStored;
  } ocpm_cfg_t;

  localparam ocpm_cfg_t DEF_CFG = '{DEF_GAIN, DEF_CREEP, DEF_MON, DEF_CAL, DEF_LED, DEF_LEV, 1'b0, 1'b0};

endpackage

// [rtl/ocpm_config_loader.sv]
// power-up mode select, fuse readout, test write, burn and pulse derivation
// assumes a combinational fuse read port, a datapath giving energy steps,
// and an AXI4-Lite master on the register side
`timescale 1ns/10ps

// How it works
// - every power-up reads all 70 fuse cells, then applies the active bank
// - a programmed bank 1 with its select bit set is used from then on
// - mode fixed at power-up: select low is normal, select high and direction low is programming
// - undriven select reads low, so normal operation is the default
// - in programming mode motor, fast and indicator pulses are active whatever the control bit, except during burn
// - test write loads the shadow word as live config without touching fuses
// - programmer shifts serial data on the program pin into the shadow register
// - burn walks the shadow word and fires the program pin for each set cell
// - programming mode holds until power is removed
// - 70-bit word, fixed bank fields, top two bits ignored
// - gain field, default 11
// - no-load threshold field, default 01
// - motor rate field, default 10
// - fast rate multiplier field, default 01
// - indicator rate field, default 101
// - 22-bit energy quantum threshold, default 0x6a6d4
// - threshold sets internal pulse; all three outputs derive from it
// - bit 1 chooses bank 0 or bank 1, default 0
// - defaults apply unless bit 0 reads 1
// - internal pulse whenever accumulator exceeds threshold
module ocpm_config_loader
  import ocpm_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              modeSelect,
  input  wire logic              dirPinIn,
  output logic                   dirPinOut,
  output logic                   dirPinOe,
  input  wire logic              energyNegative,
  input  wire logic              energyValid,
  input  wire logic [15:0]       energyStep,
  input  wire logic              progBit,
  input  wire logic              progShift,
  input  wire logic              progLoad,
  input  wire logic              progBurn,
  output logic [6:0]             fuseIdx,
  input  wire logic              fuseBit,
  output logic                   fuseBurnEn,
  output logic [1:0]             gainSel,
  output logic [1:0]             creepSel,
  output logic [1:0]             motorPhase,
  output logic                   fastPulse,
  output logic                   indicatorPulse,
  output logic                   progModeOut,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ==========================================================================
  // helpers

  // picks defaults or the active bank out of a full word
  function automatic ocpm_cfg_t selectCfg(input logic [WORD_W-1:0] w);
    ocpm_cfg_t c;
    int        b;
    c = DEF_CFG;
    b = w[BANK_BIT] ? BANK1_OFS : 0;
    if (w[USE_BIT]) begin
      c.gain      = w[GAIN_LSB+b +: 2];
      c.creep     = w[CREEP_LSB+b +: 2];
      c.mon       = w[MON_LSB+b +: 2];
      c.cal       = w[CAL_LSB+b +: 2];
      c.led       = w[LED_LSB+b +: 3];
      c.lev       = w[LEV_LSB+b +: LEV_W];
      c.bank      = w[BANK_BIT];
      c.useStored = 1'b1;
    end
    return c; // bits 69:68 never read
  endfunction

  // internal pulses per output pulse
  function automatic logic [9:0] divOf(input logic [3:0] sh);
    return DIV_BASE >> sh;
  endfunction

  // counts internal pulses, wraps at div; >= keeps a live rate change safe
  function automatic logic [10:0] stepCnt(input logic [9:0] cnt, input logic [9:0] div);
    logic [9:0] nx;
    nx = cnt + 10'h001;
    if (nx >= div) begin
      return {1'b1, 10'h000};
    end
    return {1'b0, nx};
  endfunction

  // ==========================================================================
  // state

  typedef struct packed {
    ocpm_state_t       st;
    logic              progMode;
    logic [6:0]        idx;
    logic [WORD_W-1:0] fuseWord;
    logic [WORD_W-1:0] shadow;
    ocpm_cfg_t         cfg;
    logic              burnEn;
    logic              dirOe;
    logic [23:0]       acc;
    logic              internalPulse;
    logic [9:0]        motorCnt;
    logic [9:0]        fastCnt;
    logic [9:0]        ledCnt;
    logic [1:0]        phase;
    logic              fastOut;
    logic              ledOut;
    logic              outEn;
    logic              awHave;
    logic              wHave;
    logic [ADDR_W-1:0] awAddr;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              bValid;
    logic [1:0]        bResp;
    logic              rValid;
    logic [31:0]       rData;
    logic [1:0]        rResp;
  } ocpm_regs_t;

  ocpm_regs_t q;
  ocpm_regs_t d;

  logic       running;
  logic       outGate;
  logic [3:0] fastSh;
  logic [2:0] ledSh;
  logic [10:0] motorStep;
  logic [10:0] fastStep;
  logic [10:0] ledStep;
  logic [23:0] accSum;

  // ==========================================================================
  // pulse derivation terms
  assign running  = (q.st == ST_RUN);
  assign outGate  = running && (q.outEn || q.progMode);
  assign fastSh   = {2'b00, q.cfg.mon} + {2'b00, q.cfg.cal} + FAST_SH;
  assign ledSh    = (q.cfg.led > LED_MAX) ? LED_MAX : q.cfg.led; // code 111 clamps
  assign motorStep = stepCnt(q.motorCnt, divOf({2'b00, q.cfg.mon}));
  assign fastStep  = stepCnt(q.fastCnt, divOf(fastSh));
  assign ledStep   = stepCnt(q.ledCnt, divOf({1'b0, ledSh}));
  assign accSum    = energyValid ? q.acc + {8'h00, energyStep} : q.acc;

  // ==========================================================================
  // next state
  always_comb begin
    d = q;
    d.fastOut = 1'b0;
    d.ledOut  = 1'b0;
    d.burnEn  = 1'b0;

    unique case (q.st)
      // first edge after release: latch the straps once; progMode is written
      // nowhere else, so the mode holds until power is removed
      ST_SAMPLE: begin
        d.progMode = modeSelect && !dirPinIn;
        d.idx      = 7'h00;
        d.st       = ST_READ;
      end
      // one cell per cycle, whole word every power-up
      ST_READ: begin
        d.fuseWord[q.idx] = fuseBit;
        if (q.idx == LAST_CELL) begin
          d.cfg   = selectCfg(d.fuseWord);
          d.dirOe = 1'b1;
          d.st    = ST_RUN;
        end else begin
          d.idx = q.idx + 7'h01;
        end
      end
      ST_RUN: begin
        if (q.progMode) begin
          if (progShift) begin
            d.shadow = {q.shadow[WORD_W-2:0], progBit};
          end
          if (progLoad) begin
            d.cfg = selectCfg(q.shadow); // volatile only
          end else if (progBurn) begin
            d.idx    = 7'h00;
            d.burnEn = q.shadow[0];
            d.st     = ST_BURN;
          end
        end
      end
      // one cell per cycle; an idle cell is skipped but still counted
      ST_BURN: begin
        if (q.idx == LAST_CELL) begin
          d.st = ST_RUN;
        end else begin
          d.idx    = q.idx + 7'h01;
          d.burnEn = q.shadow[d.idx];
        end
      end
    endcase

    // accumulator and internal pulse
    // limitation: steps above lev every cycle outgrow the subtraction and wrap acc
    d.internalPulse = running && (q.acc > {2'b00, q.cfg.lev});
    if (d.internalPulse) begin
      d.acc = accSum - {2'b00, q.cfg.lev};
    end else if (running) begin
      d.acc = accSum;
    end

    // three outputs divided from the one internal stream
    if (q.internalPulse && outGate) begin
      d.motorCnt = motorStep[9:0];
      d.fastCnt  = fastStep[9:0];
      d.ledCnt   = ledStep[9:0];
      d.fastOut  = fastStep[10];
      d.ledOut   = ledStep[10];
      if (motorStep[10]) begin
        d.phase = (q.phase == 2'b01) ? 2'b10 : 2'b01;
      end
    end

    // axi write side: take address and data in any order
    if (s_axi_awvalid && !q.awHave) begin
      d.awHave = 1'b1;
      d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.wHave) begin
      d.wHave = 1'b1;
      d.wData = s_axi_wdata;
      d.wStrb = s_axi_wstrb;
    end
    if (q.bValid && s_axi_bready) begin
      d.bValid = 1'b0;
    end
    if (q.awHave && q.wHave && !q.bValid) begin
      d.awHave = 1'b0;
      d.wHave  = 1'b0;
      d.bValid = 1'b1;
      d.bResp  = RESP_OKAY;
      if (q.awAddr[7:0] == REG_CTRL) begin
        if (q.wStrb[0]) begin
          d.outEn = q.wData[0];
        end
      end else if (q.awAddr[7:0] != REG_STATUS && q.awAddr[7:0] != REG_CFG && q.awAddr[7:0] != REG_LEV) begin
        d.bResp = RESP_SLV;
      end
    end

    // axi read side: one beat, answered the next cycle
    if (q.rValid && s_axi_rready) begin
      d.rValid = 1'b0;
    end
    if (s_axi_arvalid && !q.rValid) begin
      d.rValid = 1'b1;
      d.rResp  = RESP_OKAY;
      unique case (s_axi_araddr[7:0])
        REG_CTRL:   d.rData = {31'h0, q.outEn};
        REG_STATUS: d.rData = {24'h0, q.st, 1'b0, q.cfg.useStored, q.cfg.bank, q.progMode};
        REG_CFG:    d.rData = {21'h0, q.cfg.led, q.cfg.cal, q.cfg.mon, q.cfg.creep, q.cfg.gain};
        REG_LEV:    d.rData = {10'h0, q.cfg.lev};
        default: begin
          d.rData = 32'h0;
          d.rResp = RESP_SLV;
        end
      endcase
    end
  end

  // ==========================================================================
  // registers; nothing but constants enters under reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q        <= '0;
      q.st     <= ST_SAMPLE;
      q.cfg    <= DEF_CFG;
      q.outEn  <= CTRL_RST;
      q.phase  <= 2'b01;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // outputs
  assign dirPinOut      = q.dirOe && energyNegative;
  assign dirPinOe       = q.dirOe; // released during strap sampling
  assign fuseIdx        = q.idx;
  assign fuseBurnEn     = q.burnEn;
  assign gainSel        = q.cfg.gain;
  assign creepSel       = q.cfg.creep;
  assign motorPhase     = q.phase;
  assign fastPulse      = q.fastOut;
  assign indicatorPulse = q.ledOut;
  assign progModeOut    = q.progMode;
  assign s_axi_awready  = !q.awHave;
  assign s_axi_wready   = !q.wHave;
  assign s_axi_bvalid   = q.bValid;
  assign s_axi_bresp    = q.bResp;
  assign s_axi_arready  = !q.rValid;
  assign s_axi_rvalid   = q.rValid;
  assign s_axi_rdata    = q.rData;
  assign s_axi_rresp    = q.rResp;

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_read_whole_word: assert property (q.st == ST_SAMPLE |-> ##71 q.st == ST_RUN)
    else $error("readout did not take 70 cells");
  a_mode_held: assert property (q.st != ST_SAMPLE && $past(q.st) != ST_SAMPLE |-> $stable(q.progMode))
    else $error("mode changed after power-up");
  a_mode_strap: assert property (q.st == ST_SAMPLE |=> q.progMode == $past(modeSelect && !dirPinIn))
    else $error("mode strap decoded wrongly");
  a_default_cfg: assert property (q.st == ST_READ && q.idx == LAST_CELL && !q.fuseWord[0] |=> q.cfg == DEF_CFG)
    else $error("defaults not applied");
  a_bank1_lev: assert property (q.st == ST_READ && q.idx == LAST_CELL && q.fuseWord[0] && q.fuseWord[1]
                               |=> q.cfg.lev == $past(q.fuseWord[56:35]))
    else $error("bank 1 threshold not applied");
  a_cfg_hold: assert property (running && $past(running) && !$past(q.progMode && progLoad) |-> $stable(q.cfg))
    else $error("config changed without test write");
  a_test_load: assert property (running && q.progMode && progLoad |=> q.cfg == selectCfg($past(q.shadow)))
    else $error("test write not applied");
  a_shift_in: assert property (running && q.progMode && progShift |=> q.shadow[0] == $past(progBit))
    else $error("serial bit not shifted");
  a_normal_no_shift: assert property (!q.progMode && q.st != ST_SAMPLE |=> $stable(q.shadow))
    else $error("shadow touched in normal mode");
  a_burn_cell: assert property (q.burnEn |-> q.st == ST_BURN && q.shadow[q.idx])
    else $error("burn fired for a clear cell");
  a_pulse_thr: assert property (running && q.acc > {2'b00, q.cfg.lev} |=> q.internalPulse)
    else $error("missing internal pulse");

  // strap window, output gate, burn length, normal-mode run hold and bank 0 selection
  a_dir_released: assert property (q.st inside {ST_SAMPLE, ST_READ} |-> !dirPinOe)
    else $error("direction pin driven during strap sampling");
  a_gate_off: assert property (!outGate |=> !q.fastOut && !q.ledOut)
    else $error("pulse output while gated");
  a_burn_len: assert property (q.st == ST_RUN ##1 q.st == ST_BURN
                               |-> ##69 q.st == ST_BURN ##1 q.st == ST_RUN)
    else $error("burn did not walk 70 cells");
  a_normal_stays: assert property (running && !q.progMode |=> running)
    else $error("normal mode left the run state");
  a_bank0_lev: assert property (q.st == ST_READ && q.idx == LAST_CELL && q.fuseWord[0] && !q.fuseWord[1]
                               |=> q.cfg.lev == $past(q.fuseWord[23:2]))
    else $error("bank 0 threshold not applied");

  // main scenarios: strap, bank 1, full burn, fast pulse, test write
  c_program_pin_mode: cover property (q.st == ST_SAMPLE ##1 q.progMode);
  c_bank1: cover property (running && q.cfg.bank);
  c_burn: cover property (q.st == ST_BURN ##70 q.st == ST_RUN);
  c_fast: cover property (q.fastOut);
  c_test_load: cover property (running && q.progMode && progLoad);

endmodule

// [verification/ocpm_programmer_model.sv]
// model of the fuse cells and of the external programming equipment
// assumes the loader reads one cell a cycle and samples all inputs at rising edges
`timescale 1ns/10ps
module ocpm_programmer_model (
  input  wire logic       core_clk,
  input  wire logic [6:0] fuseIdx,
  input  wire logic       fuseBurnEn,
  output logic            fuseBit,
  output logic            modeSelect,
  output logic            progBit,
  output logic            progShift,
  output logic            progLoad,
  output logic            progBurn
);
  logic [69:0] fuseQ;
  logic        strapHigh;

  // ==========================================================================
  // fuse read port and strap; an undriven strap falls to its pull-down
  assign fuseBit    = (fuseIdx <= 7'h45) ? fuseQ[fuseIdx] : 1'b0;
  assign modeSelect = strapHigh;

  initial begin
    fuseQ     = '0;
    strapHigh = 1'b0;
    progBit   = 1'b0;
    progShift = 1'b0;
    progLoad  = 1'b0;
    progBurn  = 1'b0;
  end

  // a burnt cell stays set for good, across every later power-up
  always @(posedge core_clk) begin
    if (fuseBurnEn) begin
      fuseQ[fuseIdx] <= 1'b1;
    end
  end

  // ==========================================================================
  // serial test write, msb first so the first bit lands at the top
  task automatic test_write(input logic [69:0] w);
    for (int i = 69; i >= 0; i--) begin
      @(posedge core_clk);
      progBit   <= w[i];
      progShift <= 1'b1;
    end
    @(posedge core_clk);
    progShift <= 1'b0;
    progBit   <= ~w[0]; // data line no longer holds the last bit
    progLoad  <= 1'b1;
    @(posedge core_clk);
    progLoad <= 1'b0;
  endtask

  task automatic burn();
    @(posedge core_clk);
    progBurn <= 1'b1;
    @(posedge core_clk);
    progBurn <= 1'b0;
  endtask
endmodule

// [verification/otp_config_and_program_mode_tb.sv]
// self-checking bench of the fuse configuration loader
// assumes the loader package and the programmer model are compiled first
`timescale 1ns/10ps
module otp_config_and_program_mode_tb
  import ocpm_pkg::*;
;
  logic        core_clk, rst, energyNegative, energyValid, dirPull;
  logic [15:0] energyStep;
  wire         dirPinIn, modeSelect, progBit, progShift, progLoad, progBurn, fuseBit;
  logic        dirPinOut, dirPinOe, fuseBurnEn, fastPulse, indicatorPulse, progModeOut;
  logic [6:0]  fuseIdx;
  logic [1:0]  gainSel, creepSel, motorPhase, lastPh;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          bad_count, cmp_count, cycles, fastCnt, indCnt, motCnt, burnCnt;

  // direction pin has a pull-down while nobody drives it; dirPull lets a programmer tie it high
  assign dirPinIn = dirPinOe ? dirPinOut : dirPull;

  ocpm_config_loader DUT (.core_clk, .rst, .modeSelect, .dirPinIn, .dirPinOut, .dirPinOe, .energyNegative,
    .energyValid, .energyStep, .progBit, .progShift, .progLoad, .progBurn, .fuseIdx, .fuseBit, .fuseBurnEn,
    .gainSel, .creepSel, .motorPhase, .fastPulse, .indicatorPulse, .progModeOut, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  ocpm_programmer_model pm (.core_clk, .fuseIdx, .fuseBurnEn, .fuseBit, .modeSelect, .progBit, .progShift,
    .progLoad, .progBurn);

  // ==========================================================================
  // clock, pulse counters and hang guard
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    fastCnt += fastPulse;
    indCnt  += indicatorPulse;
    burnCnt += fuseBurnEn;
    if (motorPhase !== lastPh) motCnt++;
    lastPh = motorPhase;
    if (cycles == 60000) begin
      bad_count++;
      finish_test();
    end
  end

  // ==========================================================================
  // helpers
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [32:0] fields(logic [1:0] g, c, m, f, logic [2:0] l, logic [21:0] v);
    return {g, c, m, f, l, v};
  endfunction

  function automatic logic [31:0] cfg_of(logic [32:0] f);
    return {21'h0, f[24:22], f[26:25], f[28:27], f[30:29], f[32:31]};
  endfunction

  // strap is held through reset; straps are sampled once, readout takes 70 cycles
  task automatic powerup(input logic strap);
    @(posedge core_clk);
    pm.strapHigh <= strap;
    rst          <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (75) @(posedge core_clk);
  endtask

  // waits for the answer however long it takes; only the cycle guard ends a hang
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    r    = 2'h3;
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) begin
        r    = s_axi_bresp;
        done = 1'b1;
        s_axi_bready <= 1'b0;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    r    = 2'h3;
    d    = 'x;
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid) begin
        d    = s_axi_rdata;
        r    = s_axi_rresp;
        done = 1'b1;
        s_axi_rready <= 1'b0;
      end
    end
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    check({nm, " resp"}, {30'h0, RESP_OKAY}, {30'h0, r});
    check(nm, e, d);
  endtask

  task automatic run_energy(input int n);
    fastCnt = 0;
    indCnt  = 0;
    motCnt  = 0;
    energyValid <= 1'b1;
    repeat (n) @(posedge core_clk);
    energyValid <= 1'b0;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_defaults();
    logic [31:0] d;
    logic [1:0]  r;
    pm.fuseQ <= {2'h3, 33'h0, fields(2'h0, 2'h2, 2'h1, 2'h3, 3'h3, 22'h12345), 2'h0};
    powerup(1'b0);
    check("gain", 32'h3, {30'h0, gainSel});
    check("creep", 32'h1, {30'h0, creepSel});
    chk_reg("cfg", REG_CFG, 32'h567);
    chk_reg("lev", REG_LEV, 32'h6a6d4);
    chk_reg("status", REG_STATUS, 32'h40);
    chk_reg("ctrl", REG_CTRL, 32'h1);
    check("oe", 32'h1, {31'h0, dirPinOe});
    axi_wr(8'h40, 32'h1, r);
    check("bad wr", {30'h0, RESP_SLV}, {30'h0, r});
    axi_rd(8'h40, d, r);
    check("bad rd resp", {30'h0, RESP_SLV}, {30'h0, r});
    check("bad rd data", 32'h0, d);
    axi_wr(REG_STATUS, 32'hff, r);
    check("status wr", {30'h0, RESP_OKAY}, {30'h0, r});
    chk_reg("status ro", REG_STATUS, 32'h40);
    pm.test_write({68'h1, 2'h1});
    repeat (3) @(posedge core_clk);
    chk_reg("cfg kept", REG_CFG, 32'h567);
    // strap high but direction pin held high at power-up: still normal operation
    dirPull <= 1'b1;
    powerup(1'b1);
    check("dir strap", 32'h0, {31'h0, progModeOut});
    dirPull <= 1'b0;
  endtask

  task automatic t_banks();
    logic [32:0] f0, f1;
    f0 = fields(2'h0, 2'h2, 2'h1, 2'h3, 3'h6, 22'h2abcd);
    f1 = fields(2'h1, 2'h3, 2'h0, 2'h0, 3'h0, 22'h01357);
    for (int b = 0; b < 2; b++) begin
      pm.fuseQ <= {2'h3, f1, f0, b[0], 1'b1};
      powerup(1'b0);
      check("bank gain", {30'h0, b ? f1[32:31] : f0[32:31]}, {30'h0, gainSel});
      check("bank creep", {30'h0, b ? f1[30:29] : f0[30:29]}, {30'h0, creepSel});
      chk_reg("bank cfg", REG_CFG, cfg_of(b ? f1 : f0));
      chk_reg("bank lev", REG_LEV, {10'h0, b ? f1[21:0] : f0[21:0]});
      chk_reg("bank st", REG_STATUS, 32'h44 | (b << 1));
    end
  endtask

  task automatic t_program();
    logic [32:0] f0;
    logic [69:0] w;
    logic [1:0]  r;
    f0 = fields(2'h2, 2'h0, 2'h1, 2'h2, 3'h6, 22'h2abcd);
    w  = {2'h0, 33'h0, f0, 1'b0, 1'b1};
    pm.fuseQ <= '0;
    powerup(1'b1);
    check("program_pin", 32'h1, {31'h0, progModeOut});
    pm.test_write(w);
    repeat (2) @(posedge core_clk);
    chk_reg("tw cfg", REG_CFG, cfg_of(f0));
    chk_reg("tw lev", REG_LEV, {10'h0, f0[21:0]});
    check("tw fuses", 32'h0, {31'h0, |pm.fuseQ});
    axi_wr(REG_CTRL, 32'h0, r);
    run_energy(3000);
    check("program_pin pulses", 32'h1, {31'h0, fastCnt > 0 && indCnt > 0 && motCnt > 0});
    burnCnt = 0;
    pm.burn();
    repeat (80) @(posedge core_clk);
    check("burn count", $countones(w), burnCnt);
    check("burn fuses", 32'h1, {31'h0, pm.fuseQ === w});
    pm.strapHigh <= 1'b0;
    repeat (5) @(posedge core_clk);
    check("program_pin held", 32'h1, {31'h0, progModeOut});
    powerup(1'b0);
    check("normal", 32'h0, {31'h0, progModeOut});
    chk_reg("burnt cfg", REG_CFG, cfg_of(f0));
  endtask

  // default dividers: fast every 8, indicator every 16, motor every 128 internal pulses
  task automatic t_pulses();
    logic [1:0] r;
    pm.fuseQ <= '0;
    powerup(1'b0);
    energyNegative <= 1'b1;
    run_energy(12000);
    check("dir out", 32'h1, {31'h0, dirPinOut});
    check("fast ratio", 32'h1, {31'h0, (fastCnt - 2 * indCnt) inside {[-2:2]} && indCnt > 50});
    check("motor ratio", 32'h1, {31'h0, (indCnt - 8 * motCnt) inside {[-8:8]}});
    axi_wr(REG_CTRL, 32'h0, r);
    run_energy(2000);
    check("gated", 32'h0, fastCnt + indCnt + motCnt);
  endtask

  task automatic finish_test();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    rst            = 1'b1;
    energyNegative = 1'b0;
    energyValid    = 1'b0;
    dirPull        = 1'b0;
    energyStep     = 16'hffff;
    s_axi_awaddr   = 8'h00;
    s_axi_araddr   = 8'h00;
    s_axi_wdata    = 32'h0;
    s_axi_wstrb    = 4'hf;
    s_axi_awvalid  = 1'b0;
    s_axi_wvalid   = 1'b0;
    s_axi_bready   = 1'b0;
    s_axi_arvalid  = 1'b0;
    s_axi_rready   = 1'b0;
    t_defaults();
    t_banks();
    t_program();
    t_pulses();
    finish_test();
  end
endmodule
